/* File: hdl/dcu_top.sv */
module dcu_top #(
  parameter int RESET_CYC  = dcu_pkg::RESET_CYC_DFLT,
  parameter int FIFO_DEPTH = dcu_pkg::FIFO_DEPTH_DFLT,
  parameter int CALC_CYC   = dcu_pkg::CALC_CYC_DFLT
) (
  // system
  input  wire logic                sys_clk,
  input  wire logic                sys_rst,
  input  wire logic                clk_en,
  // serial link
  input  wire logic                ser_clk,
  input  wire logic                frame_sync_n,
  input  wire logic                ser_din,
  output logic                     serial_chain_out,
  // board pins and parallel port
  input  wire dcu_pkg::dcu_pins_s  pins,
  // status and outputs
  output logic                     busy_n,
  output logic                     iface_awake,
  output logic                     out_hiz,
  output logic                     out_gnd,
  output logic [dcu_pkg::NUM_CH-1:0][dcu_pkg::CODE_W-1:0] dac_code
);
  import dcu_pkg::*;

  localparam int QW = $clog2(FIFO_DEPTH);

  // refuse values the counters cannot hold
  if (FIFO_DEPTH < 2 || (1 << QW) != FIFO_DEPTH) begin : g_chk_fifo
    $error("fifo depth must be a power of two");
  end
  if (RESET_CYC <= NUM_CH || RESET_CYC >= (1 << SEQ_W) || CALC_CYC < 1) begin : g_chk_cyc
    $error("reset or calc cycle count out of range");
  end

  // ---------------- link domain ----------------
  logic [4:0]        bit_cnt_ff;
  logic [WORD_W-1:0] shift_ff;
  logic [WORD_W-1:0] hold_ff;
  logic              word_tgl_ff;
  logic              chain_out_ff;
  logic [WORD_W-1:0] rb_word_ff;
  wire               link_rst = sys_rst | frame_sync_n;
  wire               word_done = bit_cnt_ff == 5'(WORD_W - 1);
  wire [WORD_W-1:0]  rb_shift = rb_word_ff << bit_cnt_ff;

  // frame high holds the counter at zero, so a short frame never completes
  always_ff @(negedge ser_clk or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt_ff <= '0;
      shift_ff <= '0;
    end else if (bit_cnt_ff != 5'(WORD_W)) begin
      shift_ff <= {shift_ff[WORD_W-2:0], ser_din};
      bit_cnt_ff <= bit_cnt_ff + 5'h01;
    end
  end

  // complete word is parked and announced by a toggle
  always_ff @(negedge ser_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_ff <= '0;
      word_tgl_ff <= 1'b0;
    end else if (!frame_sync_n && word_done) begin
      hold_ff <= {shift_ff[WORD_W-2:0], ser_din};
      word_tgl_ff <= ~word_tgl_ff;
    end
  end

  // readback bits leave on the rising edge, held stable for the falling one
  always_ff @(posedge ser_clk or posedge sys_rst) begin
    if (sys_rst) begin
      chain_out_ff <= 1'b0;
    end else begin
      chain_out_ff <= rb_shift[WORD_W-1];
    end
  end

  assign serial_chain_out = chain_out_ff;

  // ---------------- synchronisers ----------------
  dcu_pins_s pins_m_ff, pins_s_ff, pins_p_ff;
  logic [1:0] lnk_m_ff, lnk_s_ff, lnk_p_ff;

  // first stage feeds only the second
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pins_m_ff <= PINS_RST;
      pins_s_ff <= PINS_RST;
      pins_p_ff <= PINS_RST;
      lnk_m_ff <= 2'h2;
      lnk_s_ff <= 2'h2;
      lnk_p_ff <= 2'h2;
    end else if (clk_en) begin
      pins_m_ff <= pins;
      pins_s_ff <= pins_m_ff;
      pins_p_ff <= pins_s_ff;
      lnk_m_ff <= {frame_sync_n, word_tgl_ff};
      lnk_s_ff <= lnk_m_ff;
      lnk_p_ff <= lnk_s_ff;
    end
  end

  // ---------------- decode ----------------
  dcu_state_e        state_ff;
  dcu_seq_e          seq_kind_ff;
  logic [SEQ_W-1:0]  seq_cnt_ff;
  logic [CH_W-1:0]   calc_ch_ff;
  logic [NUM_CH-1:0] calc_pend_ff;
  logic [NUM_CH-1:0] changed_ff;
  logic              load_pend_ff;
  logic              busy_n_ff;
  logic              busy_d_ff;
  logic              fifo_en_ff;
  logic              por_hiz_ff;
  logic              awake_ff;
  logic              out_hiz_ff;
  logic              out_gnd_ff;
  logic [CODE_W-1:0] clear_code_ff;
  logic [9:0]        rb_hdr_ff;
  logic [QW:0]       q_cnt_ff;
  logic [QW-1:0]     q_wr_ff;
  logic [QW-1:0]     q_rd_ff;
  logic [WORD_W-1:0] q_mem [FIFO_DEPTH];
  logic [CODE_W-1:0] input_data_reg [NUM_CH];
  logic [CODE_W-1:0] gain_mem [NUM_CH];
  logic [CODE_W-1:0] offs_mem [NUM_CH];
  logic [CODE_W-1:0] corrected_data_reg [NUM_CH];
  logic [NUM_CH-1:0][CODE_W-1:0] dac_ff;

  // edges are taken between the second and third stages only
  wire rst_fall = pins_p_ff.reset_n & ~pins_s_ff.reset_n;
  wire clr_fall = pins_p_ff.clear_to_code_n & ~pins_s_ff.clear_to_code_n;
  wire load_fall = pins_p_ff.load_outputs_n & ~pins_s_ff.load_outputs_n;
  wire wr_fall = pins_p_ff.par_wr_n & ~pins_s_ff.par_wr_n;
  wire frm_fall = lnk_p_ff[1] & ~lnk_s_ff[1];
  wire ser_word_ev = lnk_p_ff[0] ^ lnk_s_ff[0];

  wire par_mode = ~pins_s_ff.serial_parallel_select;
  wire spi_mode = pins_s_ff.serial_parallel_select & ~pins_s_ff.protocol_select;
  wire in_seq = state_ff == ST_SEQ;
  wire par_ev = par_mode & wr_fall & ~in_seq;
  wire spi_ev = spi_mode & ~pins_s_ff.chain_enable & ser_word_ev & ~in_seq;
  wire new_valid = par_ev | spi_ev;
  wire [WORD_W-1:0] new_word = par_ev ? pins_s_ff.par_data : hold_ff;

  // queue only serves the parallel port
  wire fifo_on = fifo_en_ff & par_mode;
  wire q_full = q_cnt_ff == (QW+1)'(FIFO_DEPTH);
  wire q_push = fifo_on & new_valid & ~q_full;
  wire q_pop = fifo_on & (state_ff == ST_IDLE) & ~(|calc_pend_ff) & (q_cnt_ff != '0);
  wire apply_valid = fifo_on ? q_pop : new_valid;
  dcu_cmd_s cmd;
  assign cmd = dcu_cmd_s'(fifo_on ? q_mem[q_rd_ff] : new_word);
  wire cmd_wr = apply_valid & ~cmd.rw;
  wire cmd_rd = apply_valid & cmd.rw;
  wire wr_chan = cmd_wr & (cmd.target_reg_select != REG_CLR);
  wire wr_clr = cmd_wr & (cmd.target_reg_select == REG_CLR);
  wire [NUM_CH-1:0] set_mask = wr_chan ? (NUM_CH'(1) << cmd.channel_addr) : '0;

  // sequencing and calculation
  wire [SEQ_W-1:0] seq_len = (seq_kind_ff == SEQ_CLEAR) ? SEQ_W'(CLEAR_CYC) : SEQ_W'(RESET_CYC);
  wire seq_last = in_seq & (seq_cnt_ff == seq_len - SEQ_W'(1));
  wire sweep = in_seq & (seq_cnt_ff < SEQ_W'(NUM_CH));
  wire [CH_W-1:0] sweep_ch = seq_cnt_ff[CH_W-1:0];
  wire seq_wipe = sweep & (seq_kind_ff != SEQ_CLEAR);
  wire seq_start = rst_fall | (clr_fall & ~in_seq);
  wire calc_go = (state_ff == ST_IDLE) & (|calc_pend_ff) & ~seq_start;
  wire calc_end = (state_ff == ST_CALC) & (seq_cnt_ff == SEQ_W'(CALC_CYC - 1));
  wire busy_c = (state_ff != ST_IDLE) | (|calc_pend_ff) | (q_cnt_ff != '0);
  wire busy_rise = busy_n_ff & ~busy_d_ff;
  wire load_low = ~pins_s_ff.load_outputs_n;
  wire load_go = busy_n_ff & ~busy_c & ~seq_start & (load_pend_ff | (busy_rise & load_low));
  wire [NUM_CH-1:0] calc_mask = calc_end ? (NUM_CH'(1) << calc_ch_ff) : '0;

  // lowest pending channel goes first
  function automatic logic [CH_W-1:0] first_set(input logic [NUM_CH-1:0] v);
    logic [CH_W-1:0] r;
    r = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = CH_W'(i);
      end
    end
    return r;
  endfunction

  // corrected code: raw input scaled by gain plus offset, clamped at full scale
  function automatic logic [CODE_W-1:0] correct(input logic [CODE_W-1:0] raw,
                                                input logic [CODE_W-1:0] m,
                                                input logic [CODE_W-1:0] c);
    logic [2*CODE_W:0] prod;
    logic [CODE_W+1:0] sum;
    prod = (2*CODE_W+1)'(raw) * (2*CODE_W+1)'({1'b0, m} + 15'h0001);
    sum = {1'b0, prod[2*CODE_W:CODE_W]} + {2'h0, c};
    return (sum > {2'h0, CODE_MAX}) ? CODE_MAX : sum[CODE_W-1:0];
  endfunction

  // state machine: power-on, reset and clear sequences, then calculations
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= ST_SEQ;
      seq_kind_ff <= SEQ_POR;
      seq_cnt_ff <= '0;
    end else if (clk_en) begin
      if (rst_fall) begin
        state_ff <= ST_SEQ;
        seq_kind_ff <= SEQ_RESET;
        seq_cnt_ff <= '0;
      end else begin
        case (state_ff)
          ST_SEQ: begin
            seq_cnt_ff <= seq_last ? '0 : seq_cnt_ff + SEQ_W'(1);
            if (seq_last) begin
              state_ff <= ST_IDLE;
            end
          end
          ST_IDLE: begin
            if (clr_fall) begin
              state_ff <= ST_SEQ;
              seq_kind_ff <= SEQ_CLEAR;
              seq_cnt_ff <= '0;
            end else if (calc_go) begin
              state_ff <= ST_CALC;
              seq_cnt_ff <= '0;
            end
          end
          default: begin
            seq_cnt_ff <= seq_cnt_ff + SEQ_W'(1);
            if (clr_fall) begin
              state_ff <= ST_SEQ;
              seq_kind_ff <= SEQ_CLEAR;
              seq_cnt_ff <= '0;
            end else if (calc_end) begin
              state_ff <= ST_IDLE;
            end
          end
        endcase
      end
    end
  end

  // pending and changed flags; a new write beats the clear of its own flag
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      calc_pend_ff <= '0;
      changed_ff <= '0;
      calc_ch_ff <= '0;
      load_pend_ff <= 1'b0;
    end else if (clk_en) begin
      if (rst_fall || (in_seq && seq_kind_ff != SEQ_CLEAR)) begin
        calc_pend_ff <= '0;
        changed_ff <= '0;
        load_pend_ff <= 1'b0;
      end else begin
        calc_pend_ff <= (calc_pend_ff & ~calc_mask) | set_mask;
        changed_ff <= load_go ? '0 : (changed_ff | calc_mask);
        load_pend_ff <= (load_fall & ~in_seq) | (load_pend_ff & ~load_go);
      end
      if (calc_go) begin
        calc_ch_ff <= first_set(calc_pend_ff);
      end
    end
  end

  // channel register arrays; wiped by the sweep instead of a wide reset
  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      if (seq_wipe) begin
        input_data_reg[sweep_ch] <= DATA_RST;
        gain_mem[sweep_ch] <= GAIN_RST;
        offs_mem[sweep_ch] <= OFFS_RST;
        corrected_data_reg[sweep_ch] <= DATA_RST;
      end else begin
        if (wr_chan && cmd.target_reg_select == REG_INPUT) begin
          input_data_reg[cmd.channel_addr] <= cmd.data_bits;
        end
        if (wr_chan && cmd.target_reg_select == REG_GAIN) begin
          gain_mem[cmd.channel_addr] <= cmd.data_bits;
        end
        if (wr_chan && cmd.target_reg_select == REG_OFFS) begin
          offs_mem[cmd.channel_addr] <= cmd.data_bits;
        end
        if (calc_end) begin
          corrected_data_reg[calc_ch_ff] <= correct(input_data_reg[calc_ch_ff], gain_mem[calc_ch_ff],
                                                    offs_mem[calc_ch_ff]);
        end
      end
      if (q_push) begin
        q_mem[q_wr_ff] <= new_word;
      end
    end
  end

  // dac data registers: zeroed, loaded from clear code, or from changed codes
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dac_ff <= '0;
    end else if (clk_en) begin
      if (sweep && seq_kind_ff == SEQ_CLEAR) begin
        dac_ff[sweep_ch] <= clear_code_ff;
      end else if (seq_wipe) begin
        dac_ff[sweep_ch] <= DATA_RST;
      end else if (load_go) begin
        for (int i = 0; i < NUM_CH; i++) begin
          if (changed_ff[i]) begin
            dac_ff[i] <= corrected_data_reg[i];
          end
        end
      end
    end
  end

  // instruction queue pointers, flushed by every sequence
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q_cnt_ff <= '0;
      q_wr_ff <= '0;
      q_rd_ff <= '0;
    end else if (clk_en) begin
      if (in_seq) begin
        q_cnt_ff <= '0;
        q_wr_ff <= '0;
        q_rd_ff <= '0;
      end else begin
        q_wr_ff <= q_wr_ff + QW'(q_push);
        q_rd_ff <= q_rd_ff + QW'(q_pop);
        q_cnt_ff <= q_cnt_ff + (QW+1)'(q_push) - (QW+1)'(q_pop);
      end
    end
  end

  // clear code, readback selection and fifo enable sample
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clear_code_ff <= CLR_RST;
      rb_hdr_ff <= '0;
      fifo_en_ff <= 1'b0;
    end else if (clk_en) begin
      if (seq_wipe) begin
        clear_code_ff <= CLR_RST;
        rb_hdr_ff <= '0;
      end else if (wr_clr) begin
        clear_code_ff <= cmd.data_bits;
      end else if (cmd_rd) begin
        rb_hdr_ff <= cmd[WORD_W-1:CODE_W];
      end
      if (seq_last) begin
        fifo_en_ff <= pins_s_ff.fifo_enable;
      end
    end
  end

  // readback word: header as written, data of the chosen register
  dcu_cmd_s rb_hdr;
  logic [CODE_W-1:0] rb_data;
  assign rb_hdr = dcu_cmd_s'({rb_hdr_ff, DATA_RST});
  assign rb_data = (rb_hdr.target_reg_select == REG_INPUT) ? input_data_reg[rb_hdr.channel_addr] :
                   (rb_hdr.target_reg_select == REG_OFFS) ? offs_mem[rb_hdr.channel_addr] :
                   (rb_hdr.target_reg_select == REG_GAIN) ? gain_mem[rb_hdr.channel_addr] : clear_code_ff;

  // word only changes between frames, so the link side reads it settled
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rb_word_ff <= '0;
    end else if (clk_en) begin
      rb_word_ff <= {rb_hdr_ff, rb_data};
    end
  end

  // status pins
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_n_ff <= 1'b0;
      busy_d_ff <= 1'b0;
      por_hiz_ff <= 1'b1;
      awake_ff <= 1'b0;
      out_hiz_ff <= 1'b1;
      out_gnd_ff <= 1'b0;
    end else if (clk_en) begin
      busy_n_ff <= ~(busy_c | seq_start);
      busy_d_ff <= busy_n_ff;
      if (load_go) begin
        por_hiz_ff <= 1'b0;
      end
      // interface sleeps until addressed, then stays up while work is pending
      awake_ff <= (par_mode & wr_fall) | (spi_mode & frm_fall) |
                  (awake_ff & (busy_c | ~pins_s_ff.par_wr_n | ~lnk_s_ff[1]));
      out_hiz_ff <= por_hiz_ff | (pins_s_ff.power_down & ~pins_s_ff.pd_ground);
      out_gnd_ff <= ~por_hiz_ff & pins_s_ff.power_down & pins_s_ff.pd_ground;
    end
  end

  assign busy_n = busy_n_ff;
  assign iface_awake = awake_ff;
  assign out_hiz = out_hiz_ff;
  assign out_gnd = out_gnd_ff;
  assign dac_code = dac_ff;

  // ---------------- checks ----------------
  reset_start_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && rst_fall |=> state_ff == ST_SEQ && seq_kind_ff == SEQ_RESET && seq_cnt_ff == '0)
    else $error("reset edge did not restart the sequence");

  reset_bound_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    in_seq |-> seq_cnt_ff < seq_len && !busy_n_ff)
    else $error("reset sequence overran or busy high");

  load_drop_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    in_seq && seq_kind_ff != SEQ_CLEAR && $past(in_seq) |-> !load_pend_ff)
    else $error("load stored during reset");

  calc_busy_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && state_ff == ST_CALC |=> !busy_n_ff)
    else $error("busy high during calculation");

  calc_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    state_ff == ST_CALC && !clr_fall && !rst_fall |=> $stable(dac_ff))
    else $error("outputs moved during calculation");

  stored_load_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && $rose(busy_n_ff) && load_pend_ff && !busy_c && !seq_start |-> load_go)
    else $error("stored load not done after busy rose");

  changed_only_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && load_go && !changed_ff[0] && !seq_start |=> $stable(dac_ff[0]))
    else $error("unchanged channel was loaded");

  clear_load_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && sweep && seq_kind_ff == SEQ_CLEAR && !rst_fall |=> dac_ff[$past(sweep_ch)] == clear_code_ff)
    else $error("clear code not loaded");

  fifo_cap_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && q_full && !q_pop && !in_seq |=> q_cnt_ff == (QW+1)'(FIFO_DEPTH))
    else $error("write accepted into full queue");

  bit_cap_a: assert property (@(negedge ser_clk) disable iff (sys_rst)
    bit_cnt_ff <= 5'(WORD_W))
    else $error("serial bit counter overran");

  reset_seq_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
    seq_kind_ff == SEQ_RESET && seq_last);
  clear_seq_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
    seq_kind_ff == SEQ_CLEAR && seq_last);
  load_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
    load_go && changed_ff != '0);
  fifo_full_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
    q_full && new_valid);
endmodule

/* File: hdl/dcu_pkg.sv */
// What this block does
// - only a reset pin falling edge returns all registers to power-on state.
// - after reset gain is full scale, offset zero, data registers and outputs zero.
// - reset sequence ends within 270 us; busy low from edge until done.
// - busy low from reset or power-on disables interfaces, drops load pulses.
// - after reset busy rises, normal work resumes, reset level ignored.
// - clear pin low loads every data register from clear code in 35 us.
// - input, gain or offset write recomputes corrected value, busy low meanwhile.
// - during computation writes still accepted, outputs never updated.
// - load while busy, except during a reset, power-on or clear sequence, is stored, done after busy rises; held low likewise.
// - load copies a corrected value only if written since previous load.
// - fifo enable sampled at power-up and after each clear or reset.
// - fifo works only in parallel mode; host keeps enable low otherwise.
// - fifo queues 128 instructions, drops writes when full, busy low while draining.
// - power-on reset sets registers, analog outputs high impedance, busy low.
// - power-down idles outputs hi-z or grounded, keeps register contents.
// - select pin picks parallel or serial; protocol pin low picks spi port.
// - active interface wakes only on write strobe or frame-sync falling edge.
// - chain enable low gives standalone serial port, any serial clock style.
// - frame falling edge clears bit counter; after 24 bits clocks ignored.
// - 24-bit word msb first: bank, rw, zero, address, register select, data.
// - frame rising before 24 clocks discards the frame.
// - read word selects a register shifted out in the next frame.
package dcu_pkg;
  localparam int NUM_CH = 32;
  localparam int CODE_W = 14;
  localparam int WORD_W = 24;
  localparam int CH_W = 5;
  localparam int SYS_CLK_KHZ = 50000;
  localparam int RESET_TIME_US = 270;
  localparam int CLEAR_TIME_US = 35;
  // longest times round down to whole cycles
  localparam int RESET_CYC_DFLT = RESET_TIME_US * SYS_CLK_KHZ / 1000;
  localparam int CLEAR_CYC = CLEAR_TIME_US * SYS_CLK_KHZ / 1000;
  localparam int FIFO_DEPTH_DFLT = 128;
  localparam int CALC_CYC_DFLT = 4;
  localparam int SEQ_W = 16;
  localparam logic [CODE_W-1:0] GAIN_RST = 14'h3FFF;
  localparam logic [CODE_W-1:0] OFFS_RST = 14'h0000;
  localparam logic [CODE_W-1:0] DATA_RST = 14'h0000;
  localparam logic [CODE_W-1:0] CLR_RST = 14'h0000;
  localparam logic [CODE_W-1:0] CODE_MAX = 14'h3FFF;
  localparam logic [1:0] REG_INPUT = 2'h3;
  localparam logic [1:0] REG_OFFS = 2'h2;
  localparam logic [1:0] REG_GAIN = 2'h1;
  localparam logic [1:0] REG_CLR = 2'h0;

  // serial command word, msb first
  typedef struct packed {
    logic              bank;
    logic              rw;
    logic              zero;
    logic [CH_W-1:0]   channel_addr;
    logic [1:0]        target_reg_select;
    logic [CODE_W-1:0] data_bits;
  } dcu_cmd_s;

  // static control pins from the board
  typedef struct packed {
    logic              reset_n;
    logic              clear_to_code_n;
    logic              load_outputs_n;
    logic              par_wr_n;
    logic              fifo_enable;
    logic              serial_parallel_select;
    logic              protocol_select;
    logic              chain_enable;
    logic              power_down;
    logic              pd_ground;
    logic [WORD_W-1:0] par_data;
  } dcu_pins_s;

  localparam dcu_pins_s PINS_RST = dcu_pins_s'({4'hF, 6'h00, 24'h000000});

  typedef enum logic [1:0] {ST_SEQ, ST_IDLE, ST_CALC} dcu_state_e;
  typedef enum logic [1:0] {SEQ_POR, SEQ_RESET, SEQ_CLEAR} dcu_seq_e;
endpackage

/* File: verification/dcu_host.sv */
// serial host model: clock idles high and stands still between frames
module dcu_host (
  output logic ser_clk,
  output logic frame_sync_n,
  output logic ser_din
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ser_clk = 1'b1;
    frame_sync_n = 1'b1;
    ser_din = 1'b0;
  end
  // one frame msb first, 32 ns bit period; fewer than 24 bits gives a short frame
  task automatic send(input logic [23:0] word, input int nbits);
    frame_sync_n = 1'b0;
    #16;
    for (int i = 23; i > 23 - nbits; i--) begin
      ser_din = word[i];
      #16 ser_clk = 1'b0; // data steady on both sides of the falling edge
      #16 ser_clk = 1'b1;
    end
    frame_sync_n = 1'b1;
    ser_din = ~ser_din; // a released line must not keep showing the last bit
  endtask
endmodule

/* File: verification/dac_update_control_serial_port_bench.sv */
module dac_update_control_serial_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import dcu_pkg::*;
  logic                          sys_clk = 1'b0;
  logic                          sys_rst = 1'b1;
  logic                          ser_clk, frame_sync_n, ser_din, serial_chain_out;
  logic                          busy_n, iface_awake, out_hiz, out_gnd, saw_busy;
  logic [NUM_CH-1:0][CODE_W-1:0] dac_code;
  // serial spi mode, standalone, fifo off as the host board must keep it
  dcu_pins_s pins = '{reset_n: 1'b1, clear_to_code_n: 1'b1, load_outputs_n: 1'b1, par_wr_n: 1'b1,
                      serial_parallel_select: 1'b1, default: '0};
  int errors = 0;
  int n_checks = 0;

  always #10 sys_clk = ~sys_clk;
  // remember any busy phase since last cleared
  always @(posedge sys_clk) if (busy_n === 1'b0) saw_busy <= 1'b1;
  // readback bits are valid on the falling serial clock edge
  logic [23:0] rx_word;
  always @(negedge ser_clk) rx_word <= {rx_word[22:0], serial_chain_out};

  dcu_host host (.ser_clk(ser_clk), .frame_sync_n(frame_sync_n), .ser_din(ser_din));
  // short power-on count keeps the run brief
  dcu_top #(.RESET_CYC(64)) uut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(1'b1), .ser_clk(ser_clk),
    .frame_sync_n(frame_sync_n), .ser_din(ser_din), .serial_chain_out(serial_chain_out),
    .pins(pins), .busy_n(busy_n), .iface_awake(iface_awake), .out_hiz(out_hiz),
    .out_gnd(out_gnd), .dac_code(dac_code));

  // bank bit always 0: toggle mode is never used here
  function automatic logic [23:0] cmd(input logic [4:0] ch, input logic [1:0] sel, input logic [13:0] d);
    return dcu_cmd_s'{1'b0, 1'b0, 1'b0, ch, sel, d};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // word takes a few cycles to act, so settle before polling busy
  task automatic wait_idle();
    repeat (10) @(posedge sys_clk);
    for (int i = 0; i < 4000 && busy_n !== 1'b1; i++) @(posedge sys_clk);
  endtask
  task automatic pulse_load();
    @(posedge sys_clk) pins.load_outputs_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    pins.load_outputs_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [4:0] ch, input logic [1:0] sel, input logic [13:0] d);
    host.send(cmd(ch, sel, d), 24);
    wait_idle();
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #500us;
    errors++;
    summarize();
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    // a word during power-on busy must be dropped
    host.send(cmd(5'd5, REG_INPUT, 14'h0AAA), 24);
    wait_idle();
    check(out_hiz, 1'b1);
    check(iface_awake, 1'b0);
    pulse_load();
    check(dac_code[5], 14'h0000);
    check(dac_code[9], DATA_RST);
    $display("test power_on done");
    saw_busy <= 1'b0;
    host.send(cmd(5'd3, REG_INPUT, 14'h1234), 24);
    check(iface_awake, 1'b1);
    wait_idle();
    check(saw_busy, 1'b1);
    check(dac_code[3], 14'h0000);
    pulse_load();
    check(dac_code[3], 14'h1234);
    host.send(cmd(5'd3, REG_INPUT, 14'h0111), 20);
    wait_idle();
    pulse_load();
    check(dac_code[3], 14'h1234);
    $display("test serial_write done");
    // load held low: update must follow the busy rise by itself
    @(posedge sys_clk) pins.load_outputs_n <= 1'b0;
    wr(5'd3, REG_OFFS, 14'h0010);
    repeat (4) @(posedge sys_clk);
    check(dac_code[3], 14'h1244);
    pins.load_outputs_n <= 1'b1;
    wr(5'd3, REG_GAIN, 14'h1FFF);
    pulse_load();
    check(dac_code[3], 14'h092A);
    $display("test load done");
    // power-down keeps every register; ground load or high impedance
    pins.power_down <= 1'b1;
    pins.pd_ground <= 1'b1;
    repeat (5) @(posedge sys_clk);
    check(out_gnd, 1'b1);
    check(out_hiz, 1'b0);
    pins.pd_ground <= 1'b0;
    repeat (5) @(posedge sys_clk);
    check(out_hiz, 1'b1);
    check(out_gnd, 1'b0);
    check(dac_code[3], 14'h092A);
    pins.power_down <= 1'b0;
    repeat (5) @(posedge sys_clk);
    check(out_hiz, 1'b0);
    $display("test power_down done");
    // read request for the gain of channel 3, then a nop frame carries it out
    host.send(cmd(5'd3, REG_GAIN, 14'h0000) | 24'h400000, 24);
    wait_idle();
    host.send(24'h000000, 24);
    check(rx_word[22:0], {1'b1, 1'b0, 5'd3, REG_GAIN, 14'h1FFF});
    wait_idle();
    $display("test readback done");
    wr(5'd0, REG_CLR, 14'h0200);
    @(posedge sys_clk) pins.clear_to_code_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    pins.clear_to_code_n <= 1'b1;
    wait_idle();
    check(dac_code[0], 14'h0200);
    check(dac_code[31], 14'h0200);
    $display("test clear done");
    // reset pin stays low afterwards: only its edge may count
    @(posedge sys_clk) pins.reset_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    check(busy_n, 1'b0);
    wait_idle();
    check(dac_code[31], 14'h0000);
    wr(5'd3, REG_INPUT, 14'h0055);
    pulse_load();
    check(dac_code[3], 14'h0055);
    $display("test hw_reset done");
    summarize();
  end
endmodule
